// >>> rtl/cma_array.sv
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
// =====================================================================
// Overview of operation
// - Each macrocell feedback, each ded_in input and every I/O pin drive the global bus.
// - Each block's switch matrix routes up to 40 chosen global signals inward.
// - Four cascade chains link neighbour macrocells, up to 40 product terms each.
// - Five product terms per macrocell, fed by global and regional buses.
// - Allocator steers each product term to the sum or control signals.
// - OR sums local terms plus cascade input from the neighbour.
// - XOR takes OR sum and a product term or constant level.
// - Storage data comes from XOR, a product term, or the pin.
// - Storage acts as D, T, JK, SR flip-flop or transparent latch.
// - Clock is a shared line or a product term; rising edges only.
// - With a shared clock, a low product-term enable blocks every edge.
// - Clear is global pin, product term, their OR, or off.
// - Preset is a product term or off.
// - Output and buried feedback each pick registered or combinatorial independently.
// - Pins are input, output or both; enable chosen from several sources.
// - A pin used as input keeps its macrocell working for the array.
// - Each macrocell puts an inverted product term on its four-cell regional bus.
// - Regional foldbacks allow sum terms of up to nine product terms.
// - A 16-bit user signature is writable and always readable.
// - After the protection fuse is set, configuration readback is refused.
// - Reset clears every macrocell flip-flop and all configuration; pins go undriven.
module cma_array
  import cma_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = 32'h00c0_de01  // Arbitrary identification value
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [13:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output wire logic              pready,
  output wire logic              pslverr,
  input  wire logic [2:0]        shared_clock_lines,
  input  wire logic              global_clear,
  input  wire logic [1:0]        oe_pin,
  input  wire logic [NUM_DED-1:0] ded_in,
  input  wire logic [NUM_IO-1:0] io_in,
  output wire logic [NUM_IO-1:0] io_out,
  output wire logic [NUM_IO-1:0] io_oe
);
  // =====================================================================
  // Configuration store
  logic [31:0]        ctl0   [NUM_MC];
  logic [31:0]        ctl1   [NUM_MC];
  logic [PT_IN_W-1:0] pt_t   [NUM_MC*NUM_PT];
  logic [PT_IN_W-1:0] pt_c   [NUM_MC*NUM_PT];
  logic [SEL_W-1:0]   sw_sel [NUM_SW];
  logic               fuse;
  logic [15:0]        signature;
  logic               err_q;
  logic [31:0]        next_rdata;
  logic               next_err;

  wire  logic [NUM_MC-1:0]  fb;
  wire  logic [NUM_MC-1:0]  fold;
  wire  logic [NUM_MC-1:0]  carry_out;
  wire  logic [NUM_MC-1:0]  carry_in;
  wire  logic [GBUS_W-1:0]  gbus = {ded_in, io_in, fb};
  wire  logic [SW_W-1:0]    sw_out [NUM_BLK];

  // =====================================================================
  // Address decode
  wire  logic       setup    = psel && !penable;
  wire  logic       access   = psel && penable;
  wire  logic       wr_go    = access && pwrite && clk_en && !err_q;
  wire  logic       sw_hit   = (paddr[13:11] == SW_PAGE) && (paddr[10:2] < 9'(NUM_SW));
  wire  logic [6:0] sw_idx   = paddr[8:2];
  wire  logic       mc_page  = (paddr[13:12] == MC_PAGE);
  wire  logic [4:0] mc_idx   = paddr[11:7];
  wire  logic [4:0] mc_word  = paddr[6:2];
  wire  logic       mc_hit   = mc_page && (mc_word < 5'd17);
  wire  logic       ctl_hit  = mc_word < 5'd2;
  wire  logic [4:0] pt_word  = mc_word - 5'd2;
  wire  logic [2:0] pt_sel   = 3'(pt_word / 5'd3);
  wire  logic [1:0] pt_part  = 2'(pt_word % 5'd3);
  wire  logic [7:0] pt_gi    = 8'(mc_idx) * 8'd5 + 8'(pt_sel);
  wire  logic       glob_hit = (paddr == ADDR_ID) || (paddr == ADDR_CTRL) || (paddr == ADDR_SIG)
                            || (paddr == ADDR_STAT) || (paddr == ADDR_FB);
  wire  logic       cfg_hit  = sw_hit || mc_hit;
  wire  logic       rd_block = !pwrite && cfg_hit && fuse;

  assign pready  = clk_en;
  assign pslverr = access && err_q;

  // =====================================================================
  // Read data, captured in the setup cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = !(glob_hit || cfg_hit) || rd_block;
    if (!pwrite && !rd_block) begin
      if (paddr == ADDR_ID) begin
        next_rdata = ID_VALUE;
      end else if (paddr == ADDR_CTRL || paddr == ADDR_STAT) begin
        next_rdata[CTRL_FUSE] = fuse;
      end else if (paddr == ADDR_SIG) begin
        next_rdata[15:0] = signature;
      end else if (paddr == ADDR_FB) begin
        next_rdata = fb;
      end else if (sw_hit) begin
        next_rdata[SEL_W-1:0] = sw_sel[sw_idx];
      end else if (mc_hit && ctl_hit) begin
        next_rdata = mc_word[0] ? ctl1[mc_idx] : ctl0[mc_idx];
      end else if (mc_hit) begin
        case (pt_part)
          2'd0:    next_rdata = pt_t[pt_gi][31:0];
          2'd1:    next_rdata = pt_c[pt_gi][31:0];
          default: next_rdata = {8'h00, pt_c[pt_gi][PT_IN_W-1:32], pt_t[pt_gi][PT_IN_W-1:32]};
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      err_q  <= 1'b0;
    end else if (clk_en && setup) begin
      prdata <= next_rdata;
      err_q  <= next_err;
    end
  end

  // =====================================================================
  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse      <= 1'b0;
      signature <= SIG_RST;
    end else if (wr_go) begin
      if (paddr == ADDR_CTRL && pwdata[CTRL_FUSE]) fuse <= 1'b1;
      if (paddr == ADDR_SIG) signature <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_MC; i++) begin
        ctl0[i] <= 32'h0000_0000;
        ctl1[i] <= 32'h0000_0000;
      end
      for (int i = 0; i < NUM_MC*NUM_PT; i++) begin
        pt_t[i] <= '0;
        pt_c[i] <= '0;
      end
      for (int i = 0; i < NUM_SW; i++) sw_sel[i] <= '0;
    end else if (wr_go) begin
      if (sw_hit) sw_sel[sw_idx] <= pwdata[SEL_W-1:0];
      if (mc_hit && ctl_hit && !mc_word[0]) ctl0[mc_idx] <= pwdata;
      if (mc_hit && ctl_hit && mc_word[0]) ctl1[mc_idx] <= pwdata;
      if (mc_hit && !ctl_hit && pt_part == 2'd0) pt_t[pt_gi][31:0] <= pwdata;
      if (mc_hit && !ctl_hit && pt_part == 2'd1) pt_c[pt_gi][31:0] <= pwdata;
      if (mc_hit && !ctl_hit && pt_part == 2'd2) begin
        pt_t[pt_gi][PT_IN_W-1:32] <= pwdata[11:0];
        pt_c[pt_gi][PT_IN_W-1:32] <= pwdata[23:12];
      end
    end
  end

  // =====================================================================
  // Logic blocks and macrocells
  genvar b, m;
  generate
    for (b = 0; b < NUM_BLK; b++) begin : g_blk
      cma_switch u_switch (
        .gbus   (gbus),
        .sel    (sw_sel[b*SW_W +: SW_W]),
        .sw_out (sw_out[b])
      );
    end
    for (m = 0; m < NUM_MC; m++) begin : g_mc
      if (m % CHAIN_LEN == 0) begin : g_head
        assign carry_in[m] = 1'b0;
      end else begin : g_link
        assign carry_in[m] = carry_out[m-1];
      end
      cma_macrocell u_mc (
        .pclk               (pclk),
        .presetn            (presetn),
        .clk_en             (clk_en),
        .sw_in              (sw_out[m / MC_PER_BLK]),
        .region_fb          (fold[(m / REGION) * REGION +: REGION]),
        .ctl0               (ctl0[m]),
        .ctl1               (ctl1[m]),
        .pt_true            (pt_t[m*NUM_PT +: NUM_PT]),
        .pt_comp            (pt_c[m*NUM_PT +: NUM_PT]),
        .shared_clock_lines (shared_clock_lines),
        .global_clear       (global_clear),
        .oe_pin             (oe_pin),
        .io_pin             (io_in[m]),
        .io_all             (io_in),
        .fb_all             (fb),
        .chain_carry_in     (carry_in[m]),
        .buried_fb          (fb[m]),
        .foldback           (fold[m]),
        .chain_carry_out    (carry_out[m]),
        .pin_out            (io_out[m]),
        .pin_oe             (io_oe[m])
      );
    end
  endgenerate

  // =====================================================================
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_fuse_sticky: assert property (fuse |=> fuse)
    else $error("protection fuse cleared");
  chk_fuse_set: assert property (wr_go && paddr == ADDR_CTRL && pwdata[CTRL_FUSE] |=> fuse)
    else $error("fuse write not taken");
  chk_readback_refused: assert property (clk_en && setup && !pwrite && cfg_hit && fuse
                                         |=> err_q && prdata == 32'h0000_0000)
    else $error("configuration readable after fuse");
  chk_sig_readable: assert property (clk_en && setup && !pwrite && paddr == ADDR_SIG
                                     |=> !err_q && prdata[15:0] == $past(signature))
    else $error("signature not readable");
  chk_sig_write: assert property (wr_go && paddr == ADDR_SIG |=> signature == $past(pwdata[15:0]))
    else $error("signature write lost");
  chk_switch_route: assert property (int'(sw_sel[0]) < GBUS_W |-> sw_out[0][0] == gbus[sw_sel[0]])
    else $error("switch matrix misrouted");
  chk_chain_link: assert property (carry_in[1] == carry_out[0] && !carry_in[CHAIN_LEN])
    else $error("cascade chain broken");
  chk_cfg_static: assert property (!wr_go |=> $stable(ctl0[0]) && $stable(ctl1[0]))
    else $error("configuration changed without a write");
  chk_fb_read: assert property (clk_en && setup && !pwrite && paddr == ADDR_FB |=> prdata == $past(fb))
    else $error("feedback readout mismatch");

  cov_sig_write: cover property (wr_go && paddr == ADDR_SIG);
  cov_blocked: cover property (access && err_q && fuse);
  cov_fb_active: cover property (fb != '0);
  cov_pin_drive: cover property (io_oe != '0);
endmodule

// >>> rtl/cma_pkg.sv
// =====================================================================
// Shared constants for the macrocell array
package cma_pkg;
  localparam int NUM_MC    = 32;
  localparam int NUM_IO    = 32;
  localparam int NUM_DED   = 4;
  localparam int GBUS_W    = NUM_MC + NUM_IO + NUM_DED;
  localparam int SW_W      = 40;
  localparam int NUM_BLK   = 2;
  localparam int MC_PER_BLK = 16;
  localparam int REGION    = 4;
  localparam int NUM_PT    = 5;
  localparam int PT_IN_W   = SW_W + REGION;
  localparam int CHAIN_LEN = 8;
  localparam int SEL_W     = 7;
  localparam int NUM_SW    = NUM_BLK * SW_W;
  // Register map, byte addresses
  localparam logic [13:0] ADDR_ID   = 14'h0000;
  localparam logic [13:0] ADDR_CTRL = 14'h0004;
  localparam logic [13:0] ADDR_SIG  = 14'h0008;
  localparam logic [13:0] ADDR_STAT = 14'h000c;
  localparam logic [13:0] ADDR_FB   = 14'h0010;
  localparam logic [2:0]  SW_PAGE   = 3'h1;
  localparam logic [1:0]  MC_PAGE   = 2'h1;
  localparam logic [15:0] SIG_RST   = 16'h0000;
  localparam int CTRL_FUSE = 0;
  // Control word 0 fields
  localparam int F_OR = 0;
  localparam int F_XSRC = 5;
  localparam int F_XPT = 7;
  localparam int F_DSRC = 10;
  localparam int F_DPT = 12;
  localparam int F_TYPE = 15;
  localparam int F_KPT = 18;
  localparam int F_CSRC = 21;
  localparam int F_CPT = 23;
  localparam int F_CE = 26;
  localparam int F_FBREG = 27;
  localparam int F_OREG = 28;
  localparam int F_CASC = 29;
  localparam int F_INV = 30;
  // Control word 1 fields
  localparam int F_CEPT = 0;
  localparam int F_RSRC = 3;
  localparam int F_RPT = 5;
  localparam int F_SEN = 8;
  localparam int F_SPT = 9;
  localparam int F_FPT = 12;
  localparam int F_OESEL = 15;
  localparam int F_OEIDX = 18;

  typedef enum logic [2:0] {FF_D, FF_T, FF_JK, FF_SR, FF_LATCH} cma_ff_t;

  function automatic logic cma_pt_eval(input logic [PT_IN_W-1:0] t_mask,
                                       input logic [PT_IN_W-1:0] c_mask,
                                       input logic [PT_IN_W-1:0] in);
    cma_pt_eval = &((~t_mask | in) & (~c_mask | ~in));
  endfunction
endpackage

// >>> rtl/cma_switch.sv
`timescale 1ns/1ns
// =====================================================================
// Switch matrix: picks SW_W signals of the global bus for one block
module cma_switch
  import cma_pkg::*;
(
  input  wire logic [GBUS_W-1:0] gbus,
  input  wire logic [SEL_W-1:0]  sel [SW_W],
  output wire logic [SW_W-1:0]   sw_out
);
  genvar i;
  generate
    for (i = 0; i < SW_W; i++) begin : g_sel
      // Out-of-range selections route a constant low
      assign sw_out[i] = (int'(sel[i]) < GBUS_W) ? gbus[sel[i]] : 1'b0;
    end
  endgenerate
endmodule

// >>> rtl/cma_macrocell.sv
`timescale 1ns/1ns
// =====================================================================
// One macrocell: five product terms, sum logic, storage, output select
module cma_macrocell
  import cma_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  input  wire logic [SW_W-1:0]    sw_in,
  input  wire logic [REGION-1:0]  region_fb,
  input  wire logic [31:0]        ctl0,
  input  wire logic [31:0]        ctl1,
  input  wire logic [PT_IN_W-1:0] pt_true [NUM_PT],
  input  wire logic [PT_IN_W-1:0] pt_comp [NUM_PT],
  input  wire logic [2:0]         shared_clock_lines,
  input  wire logic               global_clear,
  input  wire logic [1:0]         oe_pin,
  input  wire logic               io_pin,
  input  wire logic [NUM_IO-1:0]  io_all,
  input  wire logic [NUM_MC-1:0]  fb_all,
  input  wire logic               chain_carry_in,
  output wire logic               buried_fb,
  output wire logic               foldback,
  output wire logic               chain_carry_out,
  output wire logic               pin_out,
  output wire logic               pin_oe
);
  logic [NUM_PT-1:0]  pt;
  logic               q;
  logic               comb_q;
  logic               clk_prev;
  logic               fold_q;
  logic               next_q;
  wire  logic [PT_IN_W-1:0] pt_in = {region_fb, sw_in};
  wire  logic [1:0]   csrc  = ctl0[F_CSRC +: 2];
  wire  logic [1:0]   rsrc  = ctl1[F_RSRC +: 2];
  wire  logic [2:0]   oesel = ctl1[F_OESEL +: 3];
  wire  logic [4:0]   oeidx = ctl1[F_OEIDX +: 5];
  wire  cma_ff_t      ff_type = cma_ff_t'(ctl0[F_TYPE +: 3]);
  wire  logic         or_sum  = |(pt & ctl0[F_OR +: 5]) | chain_carry_in;
  wire  logic         xor_b   = ctl0[F_XSRC+1] ? pt[ctl0[F_XPT +: 3]] : ctl0[F_XSRC];
  wire  logic         xor_out = or_sum ^ xor_b;
  wire  logic         d_in    = ctl0[F_DSRC+1] ? io_pin : (ctl0[F_DSRC] ? pt[ctl0[F_DPT +: 3]] : xor_out);
  wire  logic         k_in    = pt[ctl0[F_KPT +: 3]];
  wire  logic         clk_sig = (csrc == 2'd3) ? pt[ctl0[F_CPT +: 3]] : shared_clock_lines[csrc];
  wire  logic         ce_ok   = !ctl0[F_CE] || (csrc == 2'd3) || pt[ctl1[F_CEPT +: 3]];
  wire  logic         rise    = clk_sig && !clk_prev;
  wire  logic         clr     = (rsrc[0] && global_clear) || (rsrc[1] && pt[ctl1[F_RPT +: 3]]);
  wire  logic         set     = ctl1[F_SEN] && pt[ctl1[F_SPT +: 3]];

  genvar k;
  generate
    for (k = 0; k < NUM_PT; k++) begin : g_pt
      assign pt[k] = cma_pt_eval(pt_true[k], pt_comp[k], pt_in);
    end
  endgenerate

  always_comb begin
    next_q = q;
    if (clr) begin
      next_q = 1'b0;
    end else if (set) begin
      next_q = 1'b1;
    end else if (ff_type == FF_LATCH) begin
      if (clk_sig && ce_ok) next_q = d_in;
    end else if (rise && ce_ok) begin
      case (ff_type)
        FF_D:    next_q = d_in;
        FF_T:    next_q = q ^ d_in;
        FF_JK:   next_q = (d_in && !q) || (!k_in && q);
        FF_SR:   next_q = d_in || (!k_in && q);
        default: next_q = q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q        <= 1'b0;
      comb_q   <= 1'b0;
      clk_prev <= 1'b0;
      fold_q   <= 1'b0;
    end else if (clk_en) begin
      q        <= next_q;
      comb_q   <= xor_out;
      clk_prev <= clk_sig;
      fold_q   <= ~pt[ctl1[F_FPT +: 3]];
    end
  end

  assign buried_fb       = ctl0[F_FBREG] ? q : comb_q;
  assign foldback        = fold_q;
  assign chain_carry_out = ctl0[F_CASC] && or_sum;
  assign pin_out         = (ctl0[F_OREG] ? q : comb_q) ^ ctl0[F_INV];
  assign pin_oe          = (oesel == 3'd1) || (oesel == 3'd2 && oe_pin[0]) || (oesel == 3'd3 && !oe_pin[0])
                        || (oesel == 3'd4 && oe_pin[1]) || (oesel == 3'd5 && !oe_pin[1])
                        || (oesel == 3'd6 && io_all[oeidx]) || (oesel == 3'd7 && fb_all[oeidx]);

  // =====================================================================
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ce_blocks: assert property (clk_en && ff_type != FF_LATCH && !clr && !set && !ce_ok |=> $stable(q))
    else $error("edge taken while clock enable low");
  chk_clear_wins: assert property (clk_en && clr |=> !q)
    else $error("clear did not force zero");
  chk_rise_only: assert property (clk_en && ff_type == FF_D && !rise && !clr && !set |=> q == $past(q))
    else $error("flip-flop changed without rising edge");
  chk_fold_invert: assert property (clk_en |=> fold_q == !$past(pt[ctl1[F_FPT +: 3]]))
    else $error("foldback not inverted term");
  chk_oe_off: assert property (oesel == 3'd0 |-> !pin_oe)
    else $error("pin driven while configured as input");
  cov_toggle: cover property (clk_en && ff_type == FF_T && rise && d_in ##1 q != $past(q));
endmodule

// >>> sim/cma_board.sv
`timescale 1ns/1ns
// =====================================================================
// Board side: drives the pins that the array leaves undriven
module cma_board
  import cma_pkg::*;
(
  input  wire logic [NUM_IO-1:0] io_out,
  input  wire logic [NUM_IO-1:0] io_oe,
  input  wire logic [NUM_IO-1:0] drive_val,
  output wire logic [NUM_IO-1:0] io_in
);
  // A pin the array drives carries the array's value, otherwise the board's
  assign io_in = (io_oe & io_out) | (~io_oe & drive_val);
endmodule

// >>> sim/cma_array_tb_top.sv
`timescale 1ns/1ns
// =====================================================================
// Self-checking bench for the macrocell array
module cma_array_tb_top;
  import cma_pkg::*;
  localparam logic [31:0] ID_X = 32'h0000_5a5a;  // Arbitrary identification value
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, global_clear, clk_en;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd, lf, drive_val, io_in, io_out, io_oe;
  logic [31:0] cfg [3];
  logic [2:0]  shared_clock_lines;
  logic [1:0]  oe_pin;
  logic [3:0]  ded_in;
  int          err_total, check_count, k, j, exp_sig;

  cma_array #(.ID_VALUE(ID_X)) cma_array_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shared_clock_lines(shared_clock_lines), .global_clear(global_clear), .oe_pin(oe_pin),
    .ded_in(ded_in), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  cma_board cma_board_i (.io_out(io_out), .io_oe(io_oe), .drive_val(drive_val), .io_in(io_in));

  // =====================================================================
  // Shared tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls pin 0 output (sel 0) or its enable (sel 1) for a few cycles
  task automatic wait_bit(input string nm, input int sel, input logic exp);
    int n;
    n = 0;
    while ((sel == 0 ? io_out[0] : io_oe[0]) !== exp && n < 8) begin
      @(posedge pclk);
      #1;
      n++;
    end
    check(nm, {31'h0, (sel == 0 ? io_out[0] : io_oe[0])}, {31'h0, exp});
  endtask

  // =====================================================================
  // Clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    close_out();
  end

  // =====================================================================
  // Tests
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; global_clear = 0;
    oe_pin = 0; shared_clock_lines = 0; ded_in = 0; drive_val = 0; lf = 32'h2938; clk_en = 1;
    err_total = 0; check_count = 0; exp_sig = 0;
    cfg = '{32'h0000_0001, 32'h4000_0001, 32'h0000_0021};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_ID, 0);    check("id", rd, ID_X);
    apb(0, ADDR_SIG, 0);   check("sig_reset", rd, exp_sig);
    apb(0, ADDR_STAT, 0);  check("stat_reset", rd, 32'h0);
    apb(0, 14'h0040, 0);   check("unmapped_err", {31'h0, er}, 32'h1);
    $display("test registers done");
    apb(1, 14'h0800, 32'h0000_0021);
    apb(1, 14'h1008, 32'h0000_0001);
    apb(1, 14'h1004, 32'h0000_8000);
    for (k = 0; k < 3; k++) begin
      apb(1, 14'h1000, cfg[k]);
      for (j = 0; j < 4; j++) begin
        lf = lfsr(lf);
        drive_val <= lf;
        ded_in    <= lf[7:4];
        wait_bit("comb_out", 0, lf[1] ^ (k != 0));
      end
    end
    wait_bit("oe_on", 1, 1'b1);
    for (k = 2; k < 6; k++) begin
      apb(1, 14'h1004, 32'(k) << 15);
      for (j = 0; j < 4; j++) begin
        oe_pin <= 2'(j);
        wait_bit("oe_sel", 1, 1'(j >> (k / 2 - 1)) ^ 1'(k % 2));
      end
    end
    $display("test comb and enable done");
    apb(1, 14'h1004, 32'h0000_8008);
    apb(1, 14'h1000, 32'h1000_0001);
    global_clear <= 1'b1;
    wait_bit("clear_init", 0, 1'b0);
    global_clear <= 1'b0;
    drive_val <= 32'h0000_0002;
    repeat (6) @(posedge pclk);
    #1 check("no_edge_hold", {31'h0, io_out[0]}, 32'h0);
    shared_clock_lines[0] <= 1'b1;
    wait_bit("rise_load", 0, 1'b1);
    drive_val <= 32'h0;
    repeat (6) @(posedge pclk);
    #1 check("high_hold", {31'h0, io_out[0]}, 32'h1);
    shared_clock_lines[0] <= 1'b0;
    repeat (6) @(posedge pclk);
    #1 check("fall_hold", {31'h0, io_out[0]}, 32'h1);
    @(posedge pclk);
    clk_en       <= 1'b0;
    global_clear <= 1'b1;
    repeat (4) @(posedge pclk);
    #1 check("frozen_out", {31'h0, io_out[0]}, 32'h1);
    check("frozen_ready", {31'h0, pready}, 32'h0);
    @(posedge pclk);
    clk_en <= 1'b1;
    wait_bit("global_clear", 0, 1'b0);
    global_clear <= 1'b0;
    $display("test registered done");
    exp_sig = 32'h0000_a5c3;
    apb(1, ADDR_SIG, 32'hffff_a5c3);
    apb(1, ADDR_CTRL, 32'h1);
    apb(0, ADDR_STAT, 0);  check("fuse_stat", rd, 32'h1);
    apb(0, ADDR_SIG, 0);   check("sig_fused", rd, exp_sig);
    apb(0, 14'h1000, 0);   check("cfg_refused", {31'h0, er}, 32'h1);
    check("cfg_data", rd, 32'h0);
    $display("test fuse done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1 check("rst_out", io_out, 32'h0);
    check("rst_oe", io_oe, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_STAT, 0);  check("stat_after_rst", rd, 32'h0);
    $display("test reset done");
    close_out();
  end
endmodule
